// ==== design/rsf_consts.vh ====
// Constants for the reset state and reset source block
// ============================================================
// Notes on behaviour
// - Reset loads the program counter from vector bytes 0000H and 0001H.
// - During reset and wait, only the program counter is undefined.
// - Data memory undefined after reset, but kept when reset hits standby.
// - Port latches 2, 3, 12 reset to 00H; their directions to FFH.
// - Memory size resets to CFH; software then writes 42H or 04H.
// - Clock registers reset to 00H, 01H, 80H, 80H, 00H, 00H, 05H.
// - Wide timer count and capture/compare to 0000H; its controls to 00H.
// - Event counter and carrier timer registers all reset to 00H.
// - Watchdog enable resets to 1AH or 9AH, chosen by the option byte.
// - Converter, amplifier and comparator control registers reset to 00H.
// - UART buffers FFH, mode 01H, error status 00H, baud control 1FH.
// - Interrupt requests and edge enables reset to 00H; masks to FFH.
// - Regulator mode control resets to 00H.
// - Watchdog flag: 0 on pin/power/default, 1 on watchdog, else kept.
// - Low-voltage flag: 0 on pin/power/default, kept on watchdog, else 1.
// - Low-voltage controls 00H on all resets, held on ordinary low-voltage.
// - Reading the reset cause register clears it to 00H.
// - After any reset, execution restarts on the internal oscillator.
`ifndef RSF_CONSTS_VH
`define RSF_CONSTS_VH

// ============================================================
// Register indices (byte address is four times the index)
`define RSF_IX_PORT_LATCH   6'd0
`define RSF_IX_PORT_DIR     6'd3
`define RSF_IX_MEM_SIZE     6'd6
`define RSF_IX_CLK_OP       6'd7
`define RSF_IX_PROC_CLK     6'd8
`define RSF_IX_INT_OSC      6'd9
`define RSF_IX_MAIN_OSC     6'd10
`define RSF_IX_MAIN_CLK     6'd11
`define RSF_IX_STAB_TIME    6'd13
`define RSF_IX_WIDE_TIMER   6'd14
`define RSF_IX_NARROW_TIMER 6'd24
`define RSF_IX_WATCHDOG     6'd32
`define RSF_IX_ANALOG       6'd33
`define RSF_IX_UART_RX      6'd40
`define RSF_IX_UART_TX      6'd41
`define RSF_IX_UART_MODE    6'd42
`define RSF_IX_UART_ERR     6'd43
`define RSF_IX_UART_BAUD    6'd44
`define RSF_IX_IRQ_REQ      6'd45
`define RSF_IX_IRQ_MASK     6'd48
`define RSF_IX_EDGE         6'd51
`define RSF_IX_REGULATOR    6'd53
`define RSF_BANK_SIZE       54
`define RSF_IX_LV_CTRL      6'd54
`define RSF_IX_LV_LEVEL     6'd55
`define RSF_IX_CAUSE        6'd56
`define RSF_IX_INT_MASK     6'd57
`define RSF_IX_INT_STATUS   6'd58
`define RSF_IX_STATE        6'd59
`define RSF_IX_PC_LO        6'd60
`define RSF_IX_PC_HI        6'd61

// ============================================================
// Reset values
`define RSF_RV_ZERO      8'h00
`define RSF_RV_ALL_ONES  8'hff
`define RSF_RV_MEM_SIZE  8'hcf
`define RSF_RV_PROC_CLK  8'h01
`define RSF_RV_OSC       8'h80
`define RSF_RV_STAB_TIME 8'h05
`define RSF_RV_WDOG_LOW  8'h1a
`define RSF_RV_WDOG_HIGH 8'h9a
`define RSF_RV_UART_MODE 8'h01
`define RSF_RV_UART_BAUD 8'h1f
`define RSF_VECTOR_LO    16'h0000
`define RSF_VECTOR_HI    16'h0001

// ============================================================
// Field positions
`define RSF_CAUSE_WDOG_BIT 4
`define RSF_CAUSE_LOWV_BIT 0
`define RSF_MAIN_CLK_SEL   0
`define RSF_EV_RUN         0
`define RSF_EV_WDOG        1
`define RSF_EV_LOWV        2

// ============================================================
// Timing: least reset processing time after release
`define RSF_PROC_TIME_NS 12000
`define RSF_CLK_PERIOD_NS 4
`define RSF_PROC_CYC ((`RSF_PROC_TIME_NS + `RSF_CLK_PERIOD_NS - 1) / `RSF_CLK_PERIOD_NS)

`endif

// ==== design/rsf_reset_seq.v ====
// Reset state sequencer, reset value bank and reset source flags
`timescale 1ns/1ps
`include "rsf_consts.vh"

module rsf_reset_seq
(
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Reset sources, asynchronous to pclk
  input  wire        reset_pin_n,
  input  wire        power_on_clear,
  input  wire        watchdog,
  input  wire        lowvolt_detector,
  input  wire        lowvolt_default,
  input  wire        wdog_option,
  // CPU core side
  input  wire        standby,
  input  wire [7:0]  vec_data,
  output reg  [15:0] vec_addr,
  output reg         vec_rd,
  output reg  [15:0] cpu_pc,
  output reg         cpu_run,
  output reg         cpu_clk_internal,
  output reg         ram_keep,
  output reg         periph_reset_n,
  // Interrupt
  output reg         irq
);

  // ============================================================
  // Sequencer states
  localparam ST_RESET = 3'd0;
  localparam ST_WAIT  = 3'd1;
  localparam ST_VLO   = 3'd2;
  localparam ST_VHI   = 3'd3;
  localparam ST_LOAD  = 3'd4;
  localparam ST_RUN   = 3'd5;

  localparam integer PROC_CYC  = `RSF_PROC_CYC;
  localparam [11:0]  PROC_LAST = PROC_CYC[11:0] - 12'd1;

  // ============================================================
  // Reset value of a bank entry
  function [7:0] rst_val;
    input [5:0] ix;
    input       opt;
    begin
      if (ix >= `RSF_IX_PORT_DIR && ix < `RSF_IX_MEM_SIZE)
        rst_val = `RSF_RV_ALL_ONES;
      else if (ix == `RSF_IX_MEM_SIZE)
        rst_val = `RSF_RV_MEM_SIZE;
      else if (ix == `RSF_IX_PROC_CLK)
        rst_val = `RSF_RV_PROC_CLK;
      else if (ix == `RSF_IX_INT_OSC || ix == `RSF_IX_MAIN_OSC)
        rst_val = `RSF_RV_OSC;
      else if (ix == `RSF_IX_STAB_TIME)
        rst_val = `RSF_RV_STAB_TIME;
      else if (ix == `RSF_IX_WATCHDOG)
        rst_val = opt ? `RSF_RV_WDOG_HIGH : `RSF_RV_WDOG_LOW;
      else if (ix == `RSF_IX_UART_RX || ix == `RSF_IX_UART_TX)
        rst_val = `RSF_RV_ALL_ONES;
      else if (ix == `RSF_IX_UART_MODE)
        rst_val = `RSF_RV_UART_MODE;
      else if (ix == `RSF_IX_UART_BAUD)
        rst_val = `RSF_RV_UART_BAUD;
      else if (ix >= `RSF_IX_IRQ_MASK && ix < `RSF_IX_EDGE)
        rst_val = `RSF_RV_ALL_ONES;
      else
        rst_val = `RSF_RV_ZERO;
    end
  endfunction

  // ============================================================
  // Source synchronisers
  reg  [5:0]  sync1_reg;
  reg  [5:0]  sync2_reg;
  wire [5:0]  src_raw;
  wire        pin_rst;
  wire        pwron_rst;
  wire        wdog_rst;
  wire        lowv_rst;
  wire        lowv_dflt;
  wire        opt_s;
  wire        int_rst;
  reg         int_rst_d_reg;
  wire        entry;

  assign src_raw   = {wdog_option, lowvolt_default, lowvolt_detector,
                      watchdog, power_on_clear, ~reset_pin_n};
  assign pin_rst   = sync2_reg[0];
  assign pwron_rst = sync2_reg[1];
  assign wdog_rst  = sync2_reg[2];
  assign lowv_rst  = sync2_reg[3];
  assign lowv_dflt = sync2_reg[4];
  assign opt_s     = sync2_reg[5];
  assign int_rst   = pin_rst | pwron_rst | wdog_rst | lowv_rst;
  assign entry     = int_rst & ~int_rst_d_reg;

  // Pin reset reads as asserted until the pin has been seen high
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg     <= 6'h01;
      sync2_reg     <= 6'h01;
      int_rst_d_reg <= 1'b1;
    end
    else
    begin
      sync1_reg     <= src_raw;
      sync2_reg     <= sync1_reg;
      int_rst_d_reg <= int_rst;
    end
  end

  // ============================================================
  // APB decode; one wait state, answer on the second access cycle
  wire [5:0]  idx;
  wire        acc;
  wire        fire;
  wire        wr_fire;
  wire        rd_fire;
  wire        mapped;

  assign idx     = paddr[7:2];
  assign mapped  = (paddr[1:0] == 2'b00) && (idx <= `RSF_IX_PC_HI);
  assign acc     = psel & penable & ~pready;
  assign fire    = psel & penable & pready;
  // Writes are dropped while the internal reset holds the bank
  assign wr_fire = fire & pwrite & mapped & ~int_rst;
  assign rd_fire = fire & ~pwrite & mapped;

  // ============================================================
  // Register bank
  reg  [7:0]  bank [0:`RSF_BANK_SIZE-1];
  reg  [7:0]  lv_ctrl_reg;
  reg  [7:0]  lv_level_reg;
  reg         wdog_flag_reg;
  reg         lowv_flag_reg;
  reg  [2:0]  int_mask_reg;
  reg  [2:0]  int_status_reg;
  reg  [2:0]  state_reg;
  reg  [11:0] wait_cnt_reg;
  integer     i;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < `RSF_BANK_SIZE; i = i + 1)
        bank[i] <= rst_val(i[5:0], 1'b0);
    end
    else
    begin
      for (i = 0; i < `RSF_BANK_SIZE; i = i + 1)
      begin
        if (int_rst)
          bank[i] <= rst_val(i[5:0], opt_s);
        else if (wr_fire && idx == i[5:0])
          bank[i] <= pwdata[7:0];
      end
    end
  end

  // ============================================================
  // Reset cause flags and low-voltage control
  wire clr_class;
  wire wdog_class;
  wire lowv_class;

  // Pin and power-on-clear win over simultaneous internal sources
  assign clr_class  = pin_rst | pwron_rst | (lowv_rst & lowv_dflt);
  assign wdog_class = ~clr_class & wdog_rst;
  assign lowv_class = ~clr_class & ~wdog_rst & lowv_rst;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdog_flag_reg <= 1'b0;
      lowv_flag_reg <= 1'b0;
      lv_ctrl_reg   <= `RSF_RV_ZERO;
      lv_level_reg  <= `RSF_RV_ZERO;
    end
    else
    begin
      // A reset entry overrides a clearing read in the same cycle
      if (entry)
      begin
        if (clr_class)
          wdog_flag_reg <= 1'b0;
        else if (wdog_class)
          wdog_flag_reg <= 1'b1;
        if (clr_class)
          lowv_flag_reg <= 1'b0;
        else if (lowv_class)
          lowv_flag_reg <= 1'b1;
      end
      else if (rd_fire && idx == `RSF_IX_CAUSE)
      begin
        wdog_flag_reg <= 1'b0;
        lowv_flag_reg <= 1'b0;
      end
      if (entry && !lowv_class)
      begin
        lv_ctrl_reg  <= `RSF_RV_ZERO;
        lv_level_reg <= `RSF_RV_ZERO;
      end
      else if (wr_fire && idx == `RSF_IX_LV_CTRL)
        lv_ctrl_reg <= pwdata[7:0];
      else if (wr_fire && idx == `RSF_IX_LV_LEVEL)
        lv_level_reg <= pwdata[7:0];
    end
  end

  // ============================================================
  // Start-up sequencer: wait, fetch vector, run
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg        <= ST_RESET;
      wait_cnt_reg     <= 12'h000;
      vec_addr         <= `RSF_VECTOR_LO;
      vec_rd           <= 1'b0;
      cpu_pc           <= 16'h0000;
      cpu_run          <= 1'b0;
      cpu_clk_internal <= 1'b1;
      ram_keep         <= 1'b0;
      periph_reset_n   <= 1'b0;
    end
    else
    begin
      periph_reset_n <= ~int_rst;
      if (entry)
        ram_keep <= standby;
      if (int_rst)
      begin
        // Program counter is not meaningful until the vector load
        state_reg        <= ST_RESET;
        cpu_run          <= 1'b0;
        vec_rd           <= 1'b0;
        cpu_clk_internal <= 1'b1;
      end
      else
      begin
        case (state_reg)
          ST_RESET:
          begin
            wait_cnt_reg <= 12'h000;
            state_reg    <= ST_WAIT;
          end
          ST_WAIT:
          begin
            if (wait_cnt_reg == PROC_LAST)
            begin
              vec_addr  <= `RSF_VECTOR_LO;
              vec_rd    <= 1'b1;
              state_reg <= ST_VLO;
            end
            else
              wait_cnt_reg <= wait_cnt_reg + 12'h001;
          end
          ST_VLO:
          begin
            vec_addr  <= `RSF_VECTOR_HI;
            state_reg <= ST_VHI;
          end
          ST_VHI:
          begin
            cpu_pc[7:0] <= vec_data;
            vec_rd      <= 1'b0;
            state_reg   <= ST_LOAD;
          end
          ST_LOAD:
          begin
            cpu_pc[15:8] <= vec_data;
            cpu_run      <= 1'b1;
            state_reg    <= ST_RUN;
          end
          ST_RUN:
          begin
            // Software may move the CPU to the main clock once running
            cpu_clk_internal <=
              ~bank[`RSF_IX_MAIN_CLK][`RSF_MAIN_CLK_SEL];
          end
          default:
            state_reg <= ST_RESET;
        endcase
      end
    end
  end

  // ============================================================
  // Interrupt status, cleared by read; a new event wins
  wire [2:0] events;

  assign events = {entry & lowv_class, entry & wdog_class,
                   ~int_rst & (state_reg == ST_LOAD)};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_status_reg <= 3'b000;
      int_mask_reg   <= 3'b000;
      irq            <= 1'b0;
    end
    else
    begin
      if (rd_fire && idx == `RSF_IX_INT_STATUS)
        int_status_reg <= events;
      else
        int_status_reg <= int_status_reg | events;
      if (wr_fire && idx == `RSF_IX_INT_MASK)
        int_mask_reg <= pwdata[2:0];
      irq <= |(int_status_reg & int_mask_reg);
    end
  end

  // ============================================================
  // APB response
  reg [7:0] rd_byte;

  always @*
  begin
    rd_byte = 8'h00;
    if (idx < `RSF_IX_LV_CTRL)
      rd_byte = bank[idx];
    else
    begin
      case (idx)
        `RSF_IX_LV_CTRL:    rd_byte = lv_ctrl_reg;
        `RSF_IX_LV_LEVEL:   rd_byte = lv_level_reg;
        `RSF_IX_CAUSE:
        begin
          rd_byte[`RSF_CAUSE_WDOG_BIT] = wdog_flag_reg;
          rd_byte[`RSF_CAUSE_LOWV_BIT] = lowv_flag_reg;
        end
        `RSF_IX_INT_MASK:   rd_byte = {5'h00, int_mask_reg};
        `RSF_IX_INT_STATUS: rd_byte = {5'h00, int_status_reg};
        `RSF_IX_STATE:
          rd_byte = {3'h0, cpu_clk_internal, ram_keep, state_reg};
        `RSF_IX_PC_LO:      rd_byte = cpu_pc[7:0];
        `RSF_IX_PC_HI:      rd_byte = cpu_pc[15:8];
        default:            rd_byte = 8'h00;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc;
      if (acc)
      begin
        pslverr <= ~mapped;
        prdata  <= (mapped && !pwrite) ? {24'h00_0000, rd_byte}
                                       : 32'h0000_0000;
      end
      else
      begin
        // Read data stands only with pready, zero in every other cycle
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

endmodule

// ==== tb/rsf_reset_chk.sv ====
// Port checker for the reset sequencer
`timescale 1ns/1ps
module rsf_reset_chk
(
  // Clock and reset
  input logic        pclk,
  input logic        presetn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Core side
  input logic [15:0] vec_addr,
  input logic        vec_rd,
  input logic        cpu_run,
  input logic        cpu_clk_internal,
  input logic        periph_reset_n
);
  // Cycles from internal reset release up to the vector fetch
  logic [11:0] rel_cnt;
  logic        rel_done;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rel_cnt  <= 12'd0;
      rel_done <= 1'b0;
    end
    else if (!periph_reset_n)
    begin
      rel_cnt  <= 12'd0;
      rel_done <= 1'b0;
    end
    else if (vec_rd)
      rel_done <= 1'b1;
    else if (!rel_done)
      rel_cnt <= rel_cnt + 12'd1;
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_pready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not in second access cycle");
  a_err_decode: assert property (psel && penable && pready |->
    pslverr == (paddr[1:0] != 2'b00 || paddr[7:2] > 6'd61))
    else $error("pslverr does not match address decode");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  a_fetch_order: assert property (vec_rd && vec_addr == 16'h0000 |=>
    vec_addr == 16'h0001 ##3 cpu_run)
    else $error("vector fetch order or run start wrong");
  a_run_internal: assert property ($rose(cpu_run) |-> cpu_clk_internal)
    else $error("run started off the internal oscillator");
  a_reset_holds: assert property (!periph_reset_n |=> !cpu_run && !vec_rd)
    else $error("core active while internal reset asserted");
  a_release_wait: assert property ($rose(vec_rd) |->
    rel_cnt >= 12'd2988 && rel_cnt <= 12'd3028)
    else $error("vector fetch not after the stabilisation wait");
  a_fetch_due: assert property (periph_reset_n && !rel_done |->
    rel_cnt <= 12'd3028)
    else $error("vector fetch missing after the stabilisation wait");

  c_run: cover property ($rose(cpu_run));
  c_err: cover property (pready && pslverr);
  c_reset: cover property ($fell(periph_reset_n));
endmodule

// ==== tb/rsf_mem_model.sv ====
// Behavioural program memory serving the reset vector
`timescale 1ns/1ps
module rsf_mem_model
#(
  parameter logic [7:0] VEC_LO = 8'h34,
  parameter logic [7:0] VEC_HI = 8'h12
)
(
  // Clock
  input  wire logic        pclk,
  // Vector fetch
  input  wire logic [15:0] vec_addr,
  input  wire logic        vec_rd,
  output logic      [7:0]  vec_data
);
  initial vec_data = 8'h00;
  // Unread cycles invert the previous output, so a stale byte reappears every second cycle
  always @(posedge pclk)
  begin
    if (vec_rd)
      vec_data <= vec_addr[0] ? VEC_HI : VEC_LO;
    else
      vec_data <= ~vec_data;
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking testbench for the reset sequencer
`timescale 1ns/1ps
`include "rsf_consts.vh"
module tb;
  // ============================================================
  // Signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        reset_pin_n = 1'b1;
  logic        power_on_clear = 1'b0;
  logic        watchdog = 1'b0;
  logic        lowvolt_detector = 1'b0;
  logic        lowvolt_default = 1'b0;
  logic        wdog_option = 1'b0;
  logic        standby = 1'b0;
  wire  [7:0]  vec_data;
  wire  [31:0] prdata;
  wire  [15:0] vec_addr, cpu_pc;
  wire         pready, pslverr, vec_rd, cpu_run, cpu_clk_internal;
  wire         ram_keep, periph_reset_n, irq;
  logic [31:0] rdv;
  logic        errv;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          srcs[3] = '{0, 1, 4};

  always #2 pclk = ~pclk;

  rsf_reset_seq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .power_on_clear,
    .watchdog, .lowvolt_detector, .lowvolt_default, .wdog_option, .standby,
    .vec_data, .vec_addr, .vec_rd, .cpu_pc, .cpu_run, .cpu_clk_internal,
    .ram_keep, .periph_reset_n, .irq);

  rsf_mem_model #(.VEC_LO(8'h34), .VEC_HI(8'h12)) mem (.pclk, .vec_addr,
    .vec_rd, .vec_data);

  // ============================================================
  // Tasks
  task summarize;
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task acc(input logic w, input logic [5:0] ix, input logic [7:0] d,
           input logic [1:0] lo = 2'b00);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {ix, lo};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      summarize;
    end
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [5:0] ix, input logic [7:0] exp, input string nm);
    acc(1'b0, ix, 8'h00);
    chk(nm, rdv, {24'h0, exp});
  endtask

  task wait_run;
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
    if (cpu_run !== 1'b1)
    begin
      n_mismatch++;
      summarize;
    end
    chk("cpu_clk_internal", cpu_clk_internal, 1);
    chk("cpu_pc", cpu_pc, 16'h1234);
  endtask

  // Source codes: 0 pin, 1 power-on clear, 2 watchdog, 3 lowvolt, 4 default
  task do_reset(input int src, input logic sb);
    @(posedge pclk);
    standby <= sb;
    {reset_pin_n, power_on_clear, watchdog, lowvolt_detector,
     lowvolt_default} <= {src != 0, src == 1, src == 2, src >= 3, src == 4};
    repeat (10) @(posedge pclk);
    {reset_pin_n, power_on_clear, watchdog, lowvolt_detector,
     lowvolt_default} <= 5'b10000;
    standby <= 1'b0;
    @(posedge pclk);
    wait_run;
    chk("ram_keep", ram_keep, sb);
  endtask

  function automatic logic [7:0] bank_rv(input int i, input logic opt);
    case (i)
      3, 4, 5, 40, 41, 48, 49, 50: return 8'hff;
      6:       return 8'hcf;
      8, 42:   return 8'h01;
      9, 10:   return 8'h80;
      13:      return 8'h05;
      32:      return opt ? 8'h9a : 8'h1a;
      44:      return 8'h1f;
      default: return 8'h00;
    endcase
  endfunction

  task check_bank(input logic opt);
    for (int i = 0; i < `RSF_BANK_SIZE; i++)
      rdchk(6'(i), bank_rv(i, opt),
        $sformatf("bank%0d", i));
  endtask

  // ============================================================
  // Sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_run;
    check_bank(1'b0);
    rdchk(`RSF_IX_CAUSE, 8'h00, "cause_por");
    // Bit 0 set in the main clock mode moves the running CPU off internal
    for (int i = 0; i < 56; i++)
      acc(1'b1, 6'(i), 8'h5b);
    rdchk(6'd0, 8'h5b, "latch_written");
    chk("cpu_clk_main", cpu_clk_internal, 0);
    acc(1'b1, `RSF_IX_MEM_SIZE, 8'h42);
    rdchk(`RSF_IX_MEM_SIZE, 8'h42, "mem_size_set");
    wdog_option <= 1'b1;
    do_reset(2, 1'b0);
    check_bank(1'b1);
    rdchk(`RSF_IX_LV_LEVEL, 8'h00, "lv_level_wdt");
    acc(1'b1, `RSF_IX_LV_CTRL, 8'h5a);
    do_reset(3, 1'b1);
    rdchk(`RSF_IX_LV_CTRL, 8'h5a, "lv_ctrl_held");
    rdchk(`RSF_IX_CAUSE, 8'h11, "cause_wdog_lowv");
    rdchk(`RSF_IX_CAUSE, 8'h00, "cause_read_clr");
    do_reset(3, 1'b0);
    do_reset(2, 1'b0);
    rdchk(`RSF_IX_CAUSE, 8'h11, "cause_lvi_held");
    foreach (srcs[k])
    begin
      acc(1'b1, `RSF_IX_LV_CTRL, 8'h5a);
      do_reset(3, 1'b0);
      do_reset(srcs[k], 1'b0);
      rdchk(`RSF_IX_CAUSE, 8'h00, "cause_cleared");
      rdchk(`RSF_IX_LV_CTRL, 8'h00, "lv_ctrl_cleared");
    end
    // Interrupt: masked, unmasked, then cleared by reading status
    acc(1'b1, `RSF_IX_INT_MASK, 8'h00);
    acc(1'b0, `RSF_IX_INT_STATUS, 8'h00);
    do_reset(2, 1'b0);
    acc(1'b1, `RSF_IX_INT_MASK, 8'h00);
    repeat (3) @(posedge pclk);
    chk("irq_masked", irq, 0);
    acc(1'b1, `RSF_IX_INT_MASK, 8'h07);
    repeat (3) @(posedge pclk);
    chk("irq_raised", irq, 1);
    rdchk(`RSF_IX_INT_STATUS, 8'h03, "int_status");
    repeat (3) @(posedge pclk);
    chk("irq_cleared", irq, 0);
    acc(1'b0, 6'd62, 8'h00);
    chk("err_index", errv, 1);
    acc(1'b1, 6'd1, 8'h77, 2'b01);
    chk("err_align", errv, 1);
    rdchk(6'd1, 8'h00, "no_effect");
    summarize;
  end
endmodule

bind rsf_reset_seq rsf_reset_chk u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .vec_addr, .vec_rd, .cpu_run,
  .cpu_clk_internal, .periph_reset_n);
